// [adcseq_top.sv]
// Conversion sequencer: power-down, response select and ready/data output
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Power-down pin low keeps device powered down, sensor supply switch open.
// - Power-down pin low resets all logic except synchronisers and read-done toggle, floats ready/data output.
// - Pin high: wait oscillator start of about 1 ms, then convert continuously.
// - Leaving power-down closes the sensor supply switch again.
// - Select low: fast response, 16.7 Hz update, 120 ms settling.
// - Select high: high-rejection response, 10 Hz update, 300 ms settling.
// - Any select level change resets modulator and filter at once.
// - After select change, ready/data goes high, converting with new response.
// - First result after change takes full settling; later ones at update rate.
// - Settling is three periods at 10 Hz, two periods at 16.7 Hz.
// - Ready/data stays high during settling, so reads then return all ones.
// - Only settled conversions load the data word, none during settling.
// - Each conversion result is 20 bits wide.
// - Ready/data falls on completion, rises again before next update if unread.
// - A read shifts 32 bits: result, four zeros, eight status bits.
// - Serial interface resets whenever a new conversion becomes available.
// - Results are offset binary: zero input gives only top bit set.
module adcseq_top
  import adcseq_pkg::*;
#(
  parameter int unsigned OSC_CYCLES         = OSC_START_CYC,
  parameter int unsigned FAST_PERIOD_CYCLES = FAST_PERIOD_CYC,
  parameter int unsigned SLOW_PERIOD_CYCLES = SLOW_PERIOD_CYC,
  parameter int unsigned LEAD_CYCLES        = RDY_LEAD_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                sclk,
  input  wire logic                powerdown_reset_n,
  input  wire logic                filter_sel,
  input  wire logic [RESULT_W-1:0] conv_result,
  output logic                     sensor_supply_switch,
  output logic                     modfilt_rst,
  output logic                     conv_done,
  output logic                     dout_o,
  output logic                     dout_oe_b
);

  // Counter must hold the longest interval; settling needs eight cycles at least
  if (OSC_CYCLES < 1 || LEAD_CYCLES < 1 || FAST_PERIOD_CYCLES <= LEAD_CYCLES ||
      SLOW_PERIOD_CYCLES <= LEAD_CYCLES || OSC_CYCLES >= 2**CNT_W ||
      FAST_PERIOD_CYCLES * FAST_SETTLE_PERIODS < 8 ||
      SLOW_PERIOD_CYCLES * SLOW_SETTLE_PERIODS < 8 ||
      FAST_PERIOD_CYCLES * FAST_SETTLE_PERIODS >= 2**CNT_W ||
      SLOW_PERIOD_CYCLES * SLOW_SETTLE_PERIODS >= 2**CNT_W) begin : g_bad_param
    $error("adcseq_top: timing parameters out of range");
  end

  // Last count value of a conversion period or of a settling interval
  function automatic logic [CNT_W-1:0] adcseq_limit(input logic slow, input logic settle);
    int unsigned per;
    per = slow ? SLOW_PERIOD_CYCLES : FAST_PERIOD_CYCLES;
    if (settle) begin
      per = per * (slow ? SLOW_SETTLE_PERIODS : FAST_SETTLE_PERIODS);
    end
    return CNT_W'(per - 1);
  endfunction : adcseq_limit

  logic [SYNC_N-1:0] async_in;
  logic [SYNC_N-1:0] s1_ff;
  logic [SYNC_N-1:0] s2_ff;
  logic [SYNC_N-1:0] s3_ff;
  logic [SYNC_N-1:0] lvl_ff;
  logic [SYNC_N-1:0] chg;

  adcseq_state_t     st_ff;
  adcseq_state_t     nxt_st;
  logic [CNT_W-1:0]  cnt_ff;
  logic [CNT_W-1:0]  nxt_cnt;
  logic              done_now;
  logic              pd_lvl;
  logic              filt_lvl;
  logic              filt_chg;
  logic              read_done;
  logic              running;
  logic              restart;
  logic              lead_hit;

  logic              sw_ff;
  logic              oe_b_ff;
  logic              modfilt_ff;
  logic              conv_done_ff;
  logic              ser_clr_ff;
  logic              rdy_ff;
  adcseq_word_t      word_ff;
  logic              shift_bit;
  logic              done_tgl;

  assign async_in = {done_tgl, filter_sel, powerdown_reset_n};

  // Three-stage synchronisers; a change counts once stages two and three agree
  for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        s1_ff[i]  <= 1'b0;
        s2_ff[i]  <= 1'b0;
        s3_ff[i]  <= 1'b0;
        lvl_ff[i] <= 1'b0;
      end else begin
        s1_ff[i] <= async_in[i];
        s2_ff[i] <= s1_ff[i];
        s3_ff[i] <= s2_ff[i];
        if (s2_ff[i] == s3_ff[i]) begin
          lvl_ff[i] <= s3_ff[i];
        end
      end
    end
    assign chg[i] = (s2_ff[i] == s3_ff[i]) && (s3_ff[i] != lvl_ff[i]);
  end

  assign pd_lvl    = lvl_ff[SYNC_PD];
  assign filt_lvl  = lvl_ff[SYNC_FILT];
  assign filt_chg  = chg[SYNC_FILT];
  assign read_done = chg[SYNC_DONE];
  assign running   = (st_ff == ADCSEQ_SETTLE) || (st_ff == ADCSEQ_RUN);
  assign restart   = running && filt_chg && pd_lvl;
  assign lead_hit  = (st_ff == ADCSEQ_RUN) &&
                     (cnt_ff == adcseq_limit(filt_lvl, 1'b0) - CNT_W'(LEAD_CYCLES));

  always_comb begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff + 1'b1;
    done_now = 1'b0;
    case (st_ff)
      ADCSEQ_PD: begin
        nxt_cnt = '0;
        if (pd_lvl) begin
          nxt_st = ADCSEQ_OSC;
        end
      end
      ADCSEQ_OSC: begin
        if (cnt_ff == CNT_W'(OSC_CYCLES - 1)) begin
          nxt_st  = ADCSEQ_SETTLE;
          nxt_cnt = '0;
        end
      end
      ADCSEQ_SETTLE: begin
        if (cnt_ff == adcseq_limit(filt_lvl, 1'b1)) begin
          nxt_st   = ADCSEQ_RUN;
          nxt_cnt  = '0;
          done_now = 1'b1;
        end
      end
      ADCSEQ_RUN: begin
        if (cnt_ff == adcseq_limit(filt_lvl, 1'b0)) begin
          nxt_cnt  = '0;
          done_now = 1'b1;
        end
      end
      default: begin
        nxt_st  = ADCSEQ_PD;
        nxt_cnt = '0;
      end
    endcase
    if (restart) begin
      nxt_st   = ADCSEQ_SETTLE;
      nxt_cnt  = '0;
      done_now = 1'b0;
    end
    if (!pd_lvl) begin
      nxt_st   = ADCSEQ_PD;
      nxt_cnt  = '0;
      done_now = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff  <= ADCSEQ_PD;
      cnt_ff <= '0;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  // Supply switch and output enable follow the power state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_ff   <= 1'b0;
      oe_b_ff <= 1'b1;
    end else begin
      sw_ff   <= (nxt_st != ADCSEQ_PD);
      oe_b_ff <= (nxt_st == ADCSEQ_PD);
    end
  end

  // Modulator and filter held in reset until the oscillator is up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      modfilt_ff <= 1'b1;
    end else begin
      modfilt_ff <= (nxt_st == ADCSEQ_PD) || (nxt_st == ADCSEQ_OSC) || restart;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_done_ff <= 1'b0;
      ser_clr_ff   <= 1'b1;
    end else begin
      conv_done_ff <= done_now;
      ser_clr_ff   <= (nxt_st == ADCSEQ_PD) || (nxt_st == ADCSEQ_OSC) ||
                      done_now || restart;
    end
  end

  // Result arrives in two's complement; flipping the top bit gives offset binary
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_ff <= WORD_RST;
    end else if (!pd_lvl) begin
      word_ff <= WORD_RST;
    end else if (done_now) begin
      word_ff.result <= {~conv_result[RESULT_W-1], conv_result[RESULT_W-2:0]};
      word_ff.pad    <= PAD_VAL;
      word_ff.status <= STATUS_BASE | (STATUS_W'(filt_lvl) << STATUS_FILT_POS);
    end
  end

  // New data wins over a read-done arriving in the same cycle
  // Power-down raises ready at once, so a wake never starts low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdy_ff <= 1'b1;
    end else if (done_now) begin
      rdy_ff <= 1'b0;
    end else if (st_ff != ADCSEQ_RUN || !pd_lvl || restart || read_done || lead_hit) begin
      rdy_ff <= 1'b1;
    end
  end

  adcseq_shift u_shift (
    .sclk       (sclk),
    .rst_b      (rst_b),
    .ser_clr    (ser_clr_ff),
    .word_i     (word_ff),
    .bit_o      (shift_bit),
    .done_tgl_o (done_tgl)
  );

  assign sensor_supply_switch = sw_ff;
  assign modfilt_rst          = modfilt_ff;
  assign conv_done            = conv_done_ff;
  assign dout_o               = rdy_ff | shift_bit;
  assign dout_oe_b            = oe_b_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_held_high;
    (dout_o && !conv_done)[*8];
  endsequence

  sequence s_filt_step;
    restart ##1 modfilt_rst;
  endsequence

  a_pd_switch_open: assert property (!pd_lvl |=> !sensor_supply_switch && modfilt_rst)
    else $error("switch not open in power-down");
  a_pd_output_float: assert property (!pd_lvl |=> dout_oe_b && rdy_ff && st_ff == ADCSEQ_PD)
    else $error("output not floated in power-down");
  a_osc_start_wait: assert property ((st_ff == ADCSEQ_OSC && pd_lvl &&
      cnt_ff == CNT_W'(OSC_CYCLES - 1)) |=> st_ff == ADCSEQ_SETTLE && !modfilt_rst)
    else $error("oscillator wait not ended on count");
  a_switch_closes: assert property ($rose(pd_lvl) |=> sensor_supply_switch && !dout_oe_b)
    else $error("switch not closed on power-up");
  a_filt_reset_pulse: assert property (s_filt_step |=> !modfilt_rst || !pd_lvl)
    else $error("modulator reset not a single pulse");
  a_filt_rdy_high: assert property (restart |=> s_held_high)
    else $error("ready not held high after select change");
  a_settle_count: assert property ((st_ff == ADCSEQ_SETTLE && pd_lvl && !filt_chg &&
      cnt_ff == adcseq_limit(filt_lvl, 1'b1)) |=> conv_done && !rdy_ff)
    else $error("first result not at settling end");
  a_rate_select: assert property ((st_ff == ADCSEQ_RUN && pd_lvl && !filt_chg &&
      cnt_ff == adcseq_limit(filt_lvl, 1'b0)) |=> conv_done ##1 !conv_done)
    else $error("update not at selected rate");
  a_lead_high: assert property (lead_hit && pd_lvl && !filt_chg |=> rdy_ff)
    else $error("ready not raised before update");
  a_word_load: assert property (conv_done |-> word_ff.result ==
      {~$past(conv_result[RESULT_W-1]), $past(conv_result[RESULT_W-2:0])} && !rdy_ff)
    else $error("result not loaded as offset binary");
  a_ser_clear: assert property (conv_done |-> ser_clr_ff && !shift_bit &&
      u_shift.bit_cnt_ff == '0)
    else $error("serial interface not reset on new result");

  // Word checks look one edge back, where the load was decided
  a_status_byte: assert property (conv_done |-> word_ff.pad == PAD_VAL &&
      word_ff.status[STATUS_FILT_POS] == $past(filt_lvl))
    else $error("pad or status bits wrong in loaded word");
  a_read_release: assert property (read_done && !done_now |=> rdy_ff)
    else $error("ready not raised after complete read");
  a_pd_word_clear: assert property (!pd_lvl |=> word_ff == WORD_RST && !conv_done)
    else $error("data word not cleared in power-down");
  a_osc_hold: assert property (st_ff == ADCSEQ_OSC |-> modfilt_rst && dout_o && !conv_done)
    else $error("conversion activity during oscillator start");

endmodule : adcseq_top
`default_nettype wire

// [adcseq_pkg.sv]
// Shared constants, data word layout and states of the conversion sequencer
package adcseq_pkg;

  localparam int unsigned CLK_MHZ             = 250;
  localparam int unsigned OSC_START_US        = 1000;
  localparam int unsigned FAST_SETTLE_MS      = 120;
  localparam int unsigned SLOW_SETTLE_MS      = 300;
  localparam int unsigned FAST_SETTLE_PERIODS = 2;
  localparam int unsigned SLOW_SETTLE_PERIODS = 3;
  localparam int unsigned RDY_LEAD_US         = 100;

  localparam int unsigned OSC_START_CYC   = OSC_START_US * CLK_MHZ;
  localparam int unsigned FAST_PERIOD_CYC = FAST_SETTLE_MS * 1000 * CLK_MHZ / FAST_SETTLE_PERIODS;
  localparam int unsigned SLOW_PERIOD_CYC = SLOW_SETTLE_MS * 1000 * CLK_MHZ / SLOW_SETTLE_PERIODS;
  localparam int unsigned RDY_LEAD_CYC    = RDY_LEAD_US * CLK_MHZ;

  localparam int unsigned CNT_W     = 27;
  localparam int unsigned RESULT_W  = 20;
  localparam int unsigned PAD_W     = 4;
  localparam int unsigned STATUS_W  = 8;
  localparam int unsigned WORD_W    = RESULT_W + PAD_W + STATUS_W;
  localparam int unsigned BIT_CNT_W = 6;
  localparam int unsigned SYNC_N    = 3;

  localparam int unsigned SYNC_PD   = 0;
  localparam int unsigned SYNC_FILT = 1;
  localparam int unsigned SYNC_DONE = 2;

  localparam int unsigned        STATUS_FILT_POS = 3;
  localparam logic [STATUS_W-1:0] STATUS_BASE    = 8'h05;
  localparam logic [PAD_W-1:0]    PAD_VAL        = 4'h0;

  typedef struct packed {
    logic [RESULT_W-1:0] result;
    logic [PAD_W-1:0]    pad;
    logic [STATUS_W-1:0] status;
  } adcseq_word_t;

  localparam adcseq_word_t WORD_RST = '{result: 20'h00000, pad: 4'h0, status: 8'h00};

  typedef enum logic [1:0] {
    ADCSEQ_PD,
    ADCSEQ_OSC,
    ADCSEQ_SETTLE,
    ADCSEQ_RUN
  } adcseq_state_t;

endpackage : adcseq_pkg

// [adcseq_shift.sv]
// Serial shifter of the ready/data output, clocked by the host serial clock
`timescale 1ns/1ps
`default_nettype none
module adcseq_shift
  import adcseq_pkg::*;
(
  input  wire logic         sclk,
  input  wire logic         rst_b,
  input  wire logic         ser_clr,
  input  wire adcseq_word_t word_i,
  output logic              bit_o,
  output logic              done_tgl_o
);

  logic                 ser_rst_b;
  logic [WORD_W-1:0]    word_v;
  logic [BIT_CNT_W-1:0] bit_cnt_ff;
  logic                 bit_ff;
  logic                 done_ff;
  logic                 tgl_ff;
  logic                 at_end;

  // Serial clock may be idle, so the clear must act without it
  assign ser_rst_b = rst_b & ~ser_clr;
  assign word_v    = word_i;
  assign at_end    = (bit_cnt_ff == BIT_CNT_W'(WORD_W));

  // Word is quasi-static: it only changes while the shifter is held clear
  always_ff @(negedge sclk or negedge ser_rst_b) begin
    if (!ser_rst_b) begin
      bit_cnt_ff <= '0;
      bit_ff     <= 1'b0;
    end else if (!at_end) begin
      bit_ff     <= word_v[WORD_W - 1 - int'(bit_cnt_ff)];
      bit_cnt_ff <= bit_cnt_ff + 1'b1;
    end else begin
      bit_ff     <= 1'b0;
    end
  end

  // Last bit is sampled on this rising edge; only then report the read
  always_ff @(posedge sclk or negedge ser_rst_b) begin
    if (!ser_rst_b) begin
      done_ff <= 1'b0;
    end else if (at_end) begin
      done_ff <= 1'b1;
    end
  end

  // Toggle survives the serial clear so no false event is made
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_ff <= 1'b0;
    end else if (at_end && !done_ff) begin
      tgl_ff <= ~tgl_ff;
    end
  end

  assign bit_o      = bit_ff;
  assign done_tgl_o = tgl_ff;

endmodule : adcseq_shift
`default_nettype wire

// [adcseq_host.sv]
// Host reader model: clocks words out of the ready/data pin
`timescale 1ns/1ps
`default_nettype none
module adcseq_host (
  output logic      sclk,
  input  wire logic dout
);
  initial sclk = 1'b1;
  // Clock stands high between frames; falls first, samples on the rise
  task automatic read(input int nbits, output logic [31:0] word);
    word = 32'h0000_0000;
    for (int k = 0; k < nbits; k++) begin
      sclk = 1'b0;
      #6;
      sclk = 1'b1;
      word = {word[30:0], dout};
      #6;
    end
  endtask : read
endmodule : adcseq_host
`default_nettype wire

// [adcseq_tb.sv]
// Self-checking bench for the conversion sequencer with a host reader
`timescale 1ns/1ps
`default_nettype none
module testbench
  import adcseq_pkg::*;
;
  // Short counts keep the run brief; expectations derive from them
  localparam int OSC = 20;
  localparam int FP  = 200;
  localparam int SP  = 300;
  localparam int LD  = 10;
  logic                clk, rst_b, powerdown_reset_n, filter_sel, sclk, dout_pin;
  logic [RESULT_W-1:0] conv_result;
  logic                sensor_supply_switch, modfilt_rst, conv_done, dout_o, dout_oe_b;
  int                  err_total  = 0;
  int                  n_compared = 0;
  int                  cyc        = 0;
  // Pull-up on the pin while the device floats it
  assign dout_pin = dout_oe_b ? 1'b1 : dout_o;
  adcseq_top #(.OSC_CYCLES(OSC), .FAST_PERIOD_CYCLES(FP), .SLOW_PERIOD_CYCLES(SP),
    .LEAD_CYCLES(LD)) DUT (.clk(clk), .rst_b(rst_b), .sclk(sclk),
    .powerdown_reset_n(powerdown_reset_n), .filter_sel(filter_sel),
    .conv_result(conv_result), .sensor_supply_switch(sensor_supply_switch),
    .modfilt_rst(modfilt_rst), .conv_done(conv_done), .dout_o(dout_o),
    .dout_oe_b(dout_oe_b));
  adcseq_host host (.sclk(sclk), .dout(dout_pin));
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      $display("ERROR %0t: %s", $time, msg);
      err_total++;
    end
  endtask : chk
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  task automatic wait_done(input int max);
    int n;
    n = 0;
    do begin
      step();
      n++;
    end while (conv_done !== 1'b1 && n < max);
  endtask : wait_done
  function automatic logic [31:0] exp_word(input logic [RESULT_W-1:0] v, input logic fs);
    return {~v[19], v[18:0], PAD_VAL, STATUS_BASE | (8'(fs) << STATUS_FILT_POS)};
  endfunction : exp_word
  task automatic t_power();
    int c0;
    @(posedge clk);
    powerdown_reset_n <= 1'b0;
    repeat (8) step();
    chk(sensor_supply_switch === 1'b0 && modfilt_rst === 1'b1, "not powered down");
    chk(dout_oe_b === 1'b1, "pin driven in power-down");
    @(posedge clk);
    powerdown_reset_n <= 1'b1;
    c0 = cyc;
    repeat (8) step();
    chk(sensor_supply_switch === 1'b1 && dout_oe_b === 1'b0, "wake outputs");
    chk(dout_o === 1'b1, "ready not high on wake");
    wait_done(OSC + 2 * FP + 40);
    chk(conv_done === 1'b1, "no first result");
    chk(cyc - c0 >= OSC + 2 * FP && cyc - c0 <= OSC + 2 * FP + 12, "first result late");
  endtask : t_power
  task automatic t_read(input logic [RESULT_W-1:0] v);
    logic [31:0] w;
    @(posedge clk);
    conv_result <= v;
    wait_done(SP + 20);
    chk(dout_o === 1'b0, "ready not low");
    repeat (2) step();
    host.read(32, w);
    chk(w === exp_word(v, filter_sel), "read word");
    repeat (8) step();
    chk(dout_o === 1'b1, "ready not high after read");
  endtask : t_read
  task automatic t_period();
    int c0;
    wait_done(FP + 20);
    c0 = cyc;
    repeat (FP - LD / 2) step();
    chk(dout_o === 1'b1, "unread result not withdrawn");
    wait_done(LD + 10);
    chk(conv_done === 1'b1 && cyc - c0 === FP, "update period");
  endtask : t_period
  task automatic t_select(input logic lvl, input int settle);
    int c0;
    logic [31:0] w;
    @(posedge clk);
    filter_sel <= lvl;
    c0 = cyc;
    for (int k = 0; k < 10 && modfilt_rst !== 1'b1; k++) step();
    chk(modfilt_rst === 1'b1 && dout_o === 1'b1, "no restart on select");
    repeat (20) step();
    host.read(32, w);
    while (conv_done !== 1'b1 && cyc - c0 < settle + 40) begin
      if (dout_o !== 1'b1) w = 32'h0000_0000;
      step();
    end
    chk(w === 32'hFFFF_FFFF, "ready not held high while settling");
    chk(conv_done === 1'b1, "no result after settling");
    chk(cyc - c0 >= settle && cyc - c0 <= settle + 12, "settle");
  endtask : t_select
  task automatic t_abort(input logic [RESULT_W-1:0] v);
    logic [31:0] w;
    wait_done(SP + 20);
    repeat (2) step();
    host.read(8, w);
    @(posedge clk);
    conv_result <= v;
    wait_done(SP + 20);
    repeat (2) step();
    host.read(32, w);
    chk(w === exp_word(v, filter_sel), "partial read not aborted");
  endtask : t_abort
  task automatic end_of_test();
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    powerdown_reset_n = 1'b0;
    filter_sel = 1'b0;
    conv_result = 20'h00000;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_power();
    t_read(20'h00000);
    t_read(20'h7FFFF);
    t_read(20'h80000);
    t_period();
    t_power();
    t_select(1'b1, 3 * SP);
    t_read(20'h12345);
    t_abort(20'h54321);
    t_select(1'b0, 2 * FP);
    t_read(20'h0ABCD);
    end_of_test();
  end
  // Run needs about 18 us; four times that cuts a hang short
  initial begin
    #72000;
    err_total++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
